// [bench/nia_cpu_model.sv]
module nia_cpu_model (
  input  wire logic                  core_clk,
  input  wire logic                  reset,
  input  wire logic                  go,
  input  wire logic [7:0]            hold,
  input  wire nia_pkg::nia_cpu_out_t cpu_out,
  output nia_pkg::nia_cpu_in_t       cpu_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       busy_r;
  logic [7:0] cnt_r;
  // vector toggles when not presented so a stale value never matches
  always_ff @(posedge core_clk) begin
    cpu_in.ack <= 1'b0;
    cpu_in.ret <= 1'b0;
    cpu_in.vector <= ~cpu_in.vector;
    if (reset) begin
      busy_r <= 1'b0;
      cnt_r <= 8'h00;
      cpu_in.vector <= 16'h0000;
    end else if (!busy_r && go && (cpu_out.irq_req || cpu_out.top_req)) begin
      cpu_in.ack <= 1'b1;
      cpu_in.vector <= {4'hC, cpu_out.chan, cpu_out.vec_addr};
      busy_r <= 1'b1;
      cnt_r <= hold;
    end else if (busy_r && cnt_r == 8'h00) begin
      cpu_in.ret <= 1'b1;
      busy_r <= 1'b0;
    end else if (busy_r) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
endmodule // nia_cpu_model

// [bench/nia_tb_top.sv]
module nia_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  core_clk;
  logic                  reset;
  logic                  clk_en;
  logic                  go;
  logic [7:0]            hold;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic [15:0]           pc_load;
  logic [3:0]            push_seq;
  logic [31:0]           q;
  int                    num_errors;
  int                    checks;
  nia_pkg::nia_apb_req_t apb;
  nia_pkg::nia_src_t     src;
  nia_pkg::nia_cpu_in_t  cpu_in;
  nia_pkg::nia_cpu_out_t cpu_out;

  nia_top u_nia_top (.core_clk(core_clk), .reset(reset), .clk_en(clk_en), .apb(apb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .src(src), .cpu_in(cpu_in),
    .cpu_out(cpu_out), .pc_load(pc_load), .push_seq(push_seq));
  nia_cpu_model u_nia_cpu_model (.core_clk(core_clk), .reset(reset), .go(go),
    .hold(hold), .cpu_out(cpu_out), .cpu_in(cpu_in));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // called just after a rising edge; pready and prdata are taken settled before the
  // edge that completes the access, then one idle edge separates transfers
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ok;
    ok = 1'b0;
    apb <= '{1'b1, 1'b0, w, a, d};
    @(posedge core_clk);
    apb.penable <= 1'b1;
    while (!ok) begin
      @(negedge core_clk);
      ok = (pready === 1'b1);
      q = prdata;
      @(posedge core_clk);
    end
    apb <= '0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  task automatic wait_cpu(input logic want_ret);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 200 && !hit; i++) begin
      @(negedge core_clk);
      hit = ((want_ret ? cpu_in.ret : cpu_in.ack) === 1'b1);
      @(posedge core_clk);
    end
    chk(hit, 1);
  endtask

  task automatic t_reset;
    rd(nia_pkg::OFS_CENTRAL, 32'h07);
    rd(nia_pkg::OFS_EXT_VECTOR, 32'h04);
    rd(nia_pkg::OFS_SRC_SELECT, 32'h03);
    $display("test reset done");
  endtask

  task automatic t_edges;
    bus(1'b1, nia_pkg::OFS_EDGE, 32'h01);
    src.pins[1:0] <= 2'b11;
    repeat (3) @(posedge core_clk);
    rd(nia_pkg::OFS_PEND, 32'h01);
    src.pins[1] <= 1'b0;
    repeat (3) @(posedge core_clk);
    rd(nia_pkg::OFS_PEND, 32'h03);
    bus(1'b1, nia_pkg::OFS_PEND, 32'h00);
    // a pulse that lives only while the block is frozen must leave no trace
    clk_en <= 1'b0;
    src.pins[2] <= 1'b1;
    @(posedge core_clk);
    src.pins[2] <= 1'b0;
    @(posedge core_clk);
    clk_en <= 1'b1;
    rd(nia_pkg::OFS_PEND, 32'h00);
    $display("test edges done");
  endtask

  task automatic t_nested;
    bus(1'b1, nia_pkg::OFS_EXT_VECTOR, 32'h54);
    bus(1'b1, nia_pkg::OFS_MASK, 32'h01);
    bus(1'b1, nia_pkg::OFS_PAIR_PRIO, 32'h01);
    bus(1'b1, nia_pkg::OFS_CENTRAL, 32'h1D);
    hold <= 8'd30;
    go <= 1'b1;
    src.pins[0] <= 1'b0;
    repeat (3) @(posedge core_clk);
    src.pins[0] <= 1'b1;
    wait_cpu(1'b0);
    rd(nia_pkg::OFS_CENTRAL, 32'h0A);
    rd(nia_pkg::OFS_SAVED_STACK, 32'h20);
    rd(nia_pkg::OFS_PEND, 32'h00);
    rd(nia_pkg::OFS_STATUS, 32'h10);
    chk(cpu_out.use_int_segment, 1);
    chk(pc_load, 32'h0000_C050);
    wait_cpu(1'b1);
    rd(nia_pkg::OFS_CENTRAL, 32'h1D);
    rd(nia_pkg::OFS_SAVED_STACK, 32'h00);
    rd(nia_pkg::OFS_STATUS, 32'h00);
    $display("test nested done");
  endtask

  task automatic t_top;
    go <= 1'b0;
    bus(1'b1, nia_pkg::OFS_SAVED_STACK, 32'h80);
    bus(1'b1, nia_pkg::OFS_SAVED_STACK, 32'h00);
    rd(nia_pkg::OFS_SAVED_STACK, 32'h80);
    bus(1'b1, nia_pkg::OFS_EXT_VECTOR, 32'h0C);
    src.nmi_pin <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(nia_pkg::OFS_CENTRAL, 32'h5D);
    chk(cpu_out.top_req, 1);
    go <= 1'b1;
    wait_cpu(1'b0);
    @(negedge core_clk);
    chk(cpu_out.dma_block, 1);
    @(posedge core_clk);
    rd(nia_pkg::OFS_CENTRAL, 32'h1D);
    wait_cpu(1'b1);
    rd(nia_pkg::OFS_SAVED_STACK, 32'h80);
    $display("test top done");
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    give_verdict();
  end

  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    go = 1'b0;
    hold = 8'd2;
    apb = '0;
    src = '0;
    num_errors = 0;
    checks = 0;
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    t_reset();
    t_edges();
    t_nested();
    t_top();
    give_verdict();
  end
endmodule // nia_tb_top

// [bench/nia_top_sva.sv]
module nia_top_sva (
  input wire logic                  core_clk,
  input wire logic                  reset,
  input wire logic                  clk_en,
  input wire nia_pkg::nia_apb_req_t apb,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire nia_pkg::nia_src_t     src,
  input wire nia_pkg::nia_cpu_in_t  cpu_in,
  input wire nia_pkg::nia_cpu_out_t cpu_out,
  input wire logic [15:0]           pc_load,
  input wire logic [3:0]            push_seq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_take;
    clk_en && cpu_in.ack;
  endsequence
  sequence s_push;
    push_seq == 4'hF || push_seq == 4'hB;
  endsequence
  property p_entry_push;
    s_take |=> s_push ##0 (push_seq[2] == $past(cpu_out.push_segment));
  endproperty
  property p_entry_vec;
    s_take |=> pc_load == $past(cpu_in.vector);
  endproperty
  property p_ret_pop;
    clk_en && cpu_in.ret |=> push_seq == 4'h1;
  endproperty
  property p_seq_idle;
    clk_en && !cpu_in.ack && !cpu_in.ret |=> push_seq == 4'h0;
  endproperty
  property p_top_take;
    s_take ##0 cpu_out.top_req |=> cpu_out.dma_block;
  endproperty
  property p_top_hold;
    clk_en && cpu_out.dma_block && !cpu_in.ret |=> cpu_out.dma_block;
  endproperty
  property p_top_excl;
    cpu_out.dma_block |-> !cpu_out.top_req && !cpu_out.irq_req;
  endproperty
  property p_top_end;
    clk_en && cpu_out.dma_block && cpu_in.ret |=> !cpu_out.dma_block;
  endproperty
  property p_bus_ok;
    !pslverr;
  endproperty
  property p_rd_wait;
    apb.psel && apb.penable && !apb.pwrite && clk_en && !pready |=> !clk_en || pready;
  endproperty
  property p_wr_ready;
    apb.psel && apb.penable && apb.pwrite && clk_en |-> pready;
  endproperty
  a_entry_push: assert property (p_entry_push) else $error("entry push order wrong");
  a_entry_vec: assert property (p_entry_vec) else $error("vector not loaded");
  a_ret_pop: assert property (p_ret_pop) else $error("return pop missing");
  a_seq_idle: assert property (p_seq_idle) else $error("stack step not one cycle");
  a_top_take: assert property (p_top_take) else $error("top entry not blocking");
  a_top_hold: assert property (p_top_hold) else $error("top block dropped");
  a_top_excl: assert property (p_top_excl) else $error("top request during top");
  a_top_end: assert property (p_top_end) else $error("top block stuck");
  a_bus_ok: assert property (p_bus_ok) else $error("bus answer wrong");
  a_rd_wait: assert property (p_rd_wait) else $error("read answer late");
  a_wr_ready: assert property (p_wr_ready) else $error("write not answered");
endmodule // nia_top_sva

bind nia_top nia_top_sva u_nia_top_sva (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
  .apb(apb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .src(src),
  .cpu_in(cpu_in), .cpu_out(cpu_out), .pc_load(pc_load), .push_seq(push_seq));

// [hw/nia_pkg.sv]
package nia_pkg;

  // register word offsets (byte addresses)
  localparam logic [7:0] OFS_CENTRAL     = 8'h00;
  localparam logic [7:0] OFS_EDGE        = 8'h04;
  localparam logic [7:0] OFS_PEND        = 8'h08;
  localparam logic [7:0] OFS_MASK        = 8'h0C;
  localparam logic [7:0] OFS_PAIR_PRIO   = 8'h10;
  localparam logic [7:0] OFS_EXT_VECTOR  = 8'h14;
  localparam logic [7:0] OFS_SAVED_STACK = 8'h18;
  localparam logic [7:0] OFS_SRC_SELECT  = 8'h1C;
  localparam logic [7:0] OFS_SEGMENT     = 8'h20;
  localparam logic [7:0] OFS_STATUS      = 8'h24;

  // central_irq_control field positions
  localparam int CEN_CPL_LSB  = 0;
  localparam int CEN_MODE_BIT = 3;
  localparam int CEN_IEN_BIT  = 4;
  localparam int CEN_TLI_BIT  = 5;
  localparam int CEN_TOP_PENDING_BIT = 6;
  // ext_vector_control field positions
  localparam int EVC_TOP_SOURCE_SELECT_BIT  = 2;
  localparam int EVC_TOP_EDGE_SELECT_BIT = 3;
  localparam int EVC_VEC_LSB   = 4;
  // saved_priority_stack: nonmaskable enable position
  localparam int SPS_TOP_NONMASKABLE_ENABLE_BIT = 7;
  // source select register positions
  localparam int SRC_A0_BIT     = 0;
  localparam int SRC_TIMER_BIT  = 1;
  localparam int SRC_SERIAL_PORT_ENABLE_BIT   = 2;
  localparam int SRC_BMS_BIT    = 3;
  localparam int SRC_ADC_BIT    = 4;
  localparam int SRC_SYNC_LSB   = 8;
  localparam int SYNC_EOFVB_BIT = 2;
  localparam int SYNC_FIELD_START_ENABLE_BIT = 3;

  // reset values
  localparam logic [2:0] RST_CPL     = 3'h7;
  localparam logic [7:0] RST_EXT_VEC = 8'h04;
  localparam logic [15:0] RST_SRC    = 16'h0003;

  typedef enum logic [1:0] { NIA_IDLE, NIA_SERVE, NIA_TOP } nia_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } nia_apb_req_t;

  typedef struct packed {
    logic [7:0] pins;
    logic       nmi_pin;
    logic       wdt_irq;
    logic       wdt_end_count;
    logic       stim_irq;
    logic       spi_irq;
    logic       adc_irq;
    logic       eofvb_evt;
    logic       field_start_event_evt;
  } nia_src_t;

  typedef struct packed {
    logic        ack;
    logic        ret;
    logic [15:0] vector;
  } nia_cpu_in_t;

  typedef struct packed {
    logic       irq_req;
    logic       top_req;
    logic [3:0] chan;
    logic [7:0] vec_addr;
    logic       push_segment;
    logic       use_int_segment;
    logic       dma_block;
  } nia_cpu_out_t;

endpackage

// [hw/nia_top.sv]
// Functional notes
// - nested acknowledge sets saved stack bit indexed by current level, unless that level is 7
// - nested acknowledge then loads current level with request level
// - entry clears enable, reloads level when nested, push order, vector loads PC
// - nested return pops, sets enable, restores level from stack
// - without segment saving, return reverts to normal segment unless nested
// - eight external pins map in order to channels a0..d1
// - edge select picks rising or falling; each source maskable
// - pair level field; even channel even level, odd gets next level
// - a0 from pin 0 when select is 1 (reset), else watchdog
// - a1 uses standard timer when timer select is 0
// - b0 from pin 2 when serial enable and bus mode are 0
// - b1 uses converter irq when converter control bit 0 is 1
// - c0 uses end-of-blank event when sync bit 2 set, else pin 4
// - c1 uses field-start event when sync bit 3 set, else pin 5
// - d0 and d1 always from pins 6 and 7
// - top source is nmi pin when select high, else watchdog end
// - top pin edge select: rising when set, falling when clear
// - selected top event sets top pending flag
// - maskable top enable requests only with global enable set
// - nonmaskable top enable is set-only, cleared only by reset
// - top service routine blocks all other interrupts and dma
// - top handling leaves enable, level and saved stack untouched
// - acknowledge only when request level strictly below current level
// - arbitration mode bit clear is concurrent, set is nested
module nia_top (
  input  wire logic                  core_clk,
  input  wire logic                  reset,
  input  wire logic                  clk_en,
  input  wire nia_pkg::nia_apb_req_t apb,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire nia_pkg::nia_src_t     src,
  input  wire nia_pkg::nia_cpu_in_t  cpu_in,
  output nia_pkg::nia_cpu_out_t      cpu_out,
  output logic [15:0]                pc_load,
  output logic [3:0]                 push_seq
);

  typedef struct packed {
    logic [7:0]          central;
    logic [7:0]          edge_sel;
    logic [7:0]          pend;
    logic [7:0]          mask;
    logic [7:0]          pair_prio;
    logic [7:0]          ext_vec;
    logic [7:0]          saved;
    logic [15:0]         srcsel;
    logic [7:0]          segment;
    logic [8:0]          chan_prev;
    logic                top_prev;
    logic                top_active;
    logic                int_seg;
    logic [31:0]         rdata;
    logic [15:0]         pc;
    logic [3:0]          seq;
    logic [3:0]          depth;
    logic                rd_ready;
    nia_pkg::nia_state_t st;
  } nia_state_all_t;

  nia_state_all_t s_r, s_nxt;

  // level of channel index c (0..7) from the pair fields
  // even/odd pair levels
  function automatic logic [2:0] chan_level(input logic [7:0] pp, input logic [2:0] c);
    logic [1:0] f;
    f = pp[{c[2:1], 1'b0} +: 2];
    chan_level = {f, c[0]};
  endfunction

  logic [7:0] chan_raw;
  logic       top_raw;
  logic [7:0] reqs;
  logic [2:0] win;
  logic       win_ok;
  logic [2:0] lowest;
  logic       stk_any;
  logic [7:0] sync;
  logic       top_en;
  logic       wr;
  logic       rd;
  logic       mode_nested;

  assign sync = s_r.srcsel[nia_pkg::SRC_SYNC_LSB +: 8];
  assign mode_nested = s_r.central[nia_pkg::CEN_MODE_BIT];
  assign wr = apb.psel & apb.penable & apb.pwrite & clk_en;
  assign rd = apb.psel & apb.penable & ~apb.pwrite;
  // reads take one wait state so prdata can come straight from a flip-flop
  assign pready = clk_en & (~rd | s_r.rd_ready);

  always_comb begin
    chan_raw = src.pins;
    chan_raw[0] = s_r.srcsel[nia_pkg::SRC_A0_BIT] ? src.pins[0] : src.wdt_irq;
    chan_raw[1] = s_r.srcsel[nia_pkg::SRC_TIMER_BIT] ? src.pins[1] : src.stim_irq;
    chan_raw[2] = (s_r.srcsel[nia_pkg::SRC_SERIAL_PORT_ENABLE_BIT] | s_r.srcsel[nia_pkg::SRC_BMS_BIT]) ?
                  src.spi_irq : src.pins[2];
    chan_raw[3] = s_r.srcsel[nia_pkg::SRC_ADC_BIT] ? src.adc_irq : src.pins[3];
    chan_raw[4] = sync[nia_pkg::SYNC_EOFVB_BIT] ? src.eofvb_evt : src.pins[4];
    chan_raw[5] = sync[nia_pkg::SYNC_FIELD_START_ENABLE_BIT] ? src.field_start_event_evt : src.pins[5];
    chan_raw[7:6] = src.pins[7:6];
    top_raw = s_r.ext_vec[nia_pkg::EVC_TOP_SOURCE_SELECT_BIT] ? src.nmi_pin : src.wdt_end_count;
  end

  // arbitration: lowest level wins, daisy chain by index on ties
  always_comb begin
    logic [2:0] best;
    best = 3'h7;
    win = 3'h0;
    win_ok = 1'b0;
    reqs = s_r.pend & s_r.mask;
    for (int i = 0; i < 8; i++) begin
      if (reqs[i] && (!win_ok || chan_level(s_r.pair_prio, 3'(i)) < best)) begin
        win_ok = 1'b1;
        win = 3'(i);
        best = chan_level(s_r.pair_prio, 3'(i));
      end
    end
    win_ok = win_ok && s_r.central[nia_pkg::CEN_IEN_BIT] &&
             (best < s_r.central[nia_pkg::CEN_CPL_LSB +: 3]);
  end

  always_comb begin
    lowest = 3'h0;
    stk_any = 1'b0;
    // bit 7 holds the nonmaskable enable, never a saved level
    for (int i = 6; i >= 0; i--) begin
      if (s_r.saved[i]) begin
        lowest = 3'(i);
        stk_any = 1'b1;
      end
    end
  end

  // maskable top enable gated by global enable
  assign top_en = s_r.central[nia_pkg::CEN_TOP_PENDING_BIT] &
                  ((s_r.central[nia_pkg::CEN_TLI_BIT] & s_r.central[nia_pkg::CEN_IEN_BIT]) |
                   s_r.saved[nia_pkg::SPS_TOP_NONMASKABLE_ENABLE_BIT]);

  always_comb begin
    logic [7:0] edge_hit;
    logic       top_hit;
    logic [7:0] wb;
    s_nxt = s_r;
    edge_hit = 8'h00;
    top_hit = 1'b0;
    wb = apb.pwdata[7:0];
    s_nxt.rd_ready = rd & ~s_r.rd_ready;
    for (int i = 0; i < 8; i++) begin
      edge_hit[i] = s_r.edge_sel[i] ? (chan_raw[i] & ~s_r.chan_prev[i]) :
                                      (~chan_raw[i] & s_r.chan_prev[i]);
    end
    // top pin edge select, timer end is rising
    top_hit = (s_r.ext_vec[nia_pkg::EVC_TOP_SOURCE_SELECT_BIT] & ~s_r.ext_vec[nia_pkg::EVC_TOP_EDGE_SELECT_BIT]) ?
              (~top_raw & s_r.top_prev) : (top_raw & ~s_r.top_prev);
    s_nxt.chan_prev = {top_raw, chan_raw};
    s_nxt.top_prev = top_raw;
    s_nxt.rdata = 32'h0000_0000;
    if (rd) begin
      case (apb.paddr)
        nia_pkg::OFS_CENTRAL:     s_nxt.rdata = {24'h0, s_r.central};
        nia_pkg::OFS_EDGE:        s_nxt.rdata = {24'h0, s_r.edge_sel};
        nia_pkg::OFS_PEND:        s_nxt.rdata = {24'h0, s_r.pend};
        nia_pkg::OFS_MASK:        s_nxt.rdata = {24'h0, s_r.mask};
        nia_pkg::OFS_PAIR_PRIO:   s_nxt.rdata = {24'h0, s_r.pair_prio};
        nia_pkg::OFS_EXT_VECTOR:  s_nxt.rdata = {24'h0, s_r.ext_vec};
        nia_pkg::OFS_SAVED_STACK: s_nxt.rdata = {24'h0, s_r.saved};
        nia_pkg::OFS_SRC_SELECT:  s_nxt.rdata = {16'h0, s_r.srcsel};
        nia_pkg::OFS_SEGMENT:     s_nxt.rdata = {24'h0, s_r.segment};
        nia_pkg::OFS_STATUS:      s_nxt.rdata = {27'h0, s_r.int_seg, s_r.top_active,
                                                 s_r.seq[2:0]};
        default:                  s_nxt.rdata = 32'h0000_0000;
      endcase
    end
    if (wr) begin
      case (apb.paddr)
        nia_pkg::OFS_CENTRAL:     s_nxt.central = wb;
        nia_pkg::OFS_EDGE:        s_nxt.edge_sel = wb;
        nia_pkg::OFS_PEND:        s_nxt.pend = wb;
        nia_pkg::OFS_MASK:        s_nxt.mask = wb;
        nia_pkg::OFS_PAIR_PRIO:   s_nxt.pair_prio = wb;
        nia_pkg::OFS_EXT_VECTOR:  s_nxt.ext_vec = wb;
        nia_pkg::OFS_SAVED_STACK: s_nxt.saved = {s_r.saved[7] | wb[7], wb[6:0]};
        nia_pkg::OFS_SRC_SELECT:  s_nxt.srcsel = apb.pwdata[15:0];
        nia_pkg::OFS_SEGMENT:     s_nxt.segment = wb;
        default:                  s_nxt.segment = s_nxt.segment;
      endcase
    end
    // hardware sets win over software clears
    s_nxt.pend = s_nxt.pend | edge_hit;
    if (top_hit) begin
      s_nxt.central[nia_pkg::CEN_TOP_PENDING_BIT] = 1'b1;
    end
    s_nxt.seq = 4'h0;
    case (s_r.st)
      nia_pkg::NIA_IDLE, nia_pkg::NIA_SERVE: begin
        if (cpu_in.ack && top_en) begin
          // top entry leaves enable and levels alone
          s_nxt.central[nia_pkg::CEN_TOP_PENDING_BIT] = top_hit;
          s_nxt.top_active = 1'b1;
          s_nxt.pc = cpu_in.vector;
          s_nxt.seq = s_r.srcsel[15] ? 4'hF : 4'hB;
          s_nxt.st = nia_pkg::NIA_TOP;
        end else if (cpu_in.ack && win_ok) begin
          s_nxt.pend[win] = edge_hit[win];
          // entry clears enable, push order, vector
          s_nxt.central[nia_pkg::CEN_IEN_BIT] = 1'b0;
          s_nxt.pc = cpu_in.vector;
          s_nxt.seq = s_r.srcsel[15] ? 4'hF : 4'hB;
          s_nxt.int_seg = ~s_r.srcsel[15];
          s_nxt.depth = s_r.depth + 4'h1;
          if (mode_nested) begin
            // save current level
            // level 7 is implied by an empty stack, so the enable in bit 7 stays intact
            if (s_r.central[2:0] != 3'h7) begin
              s_nxt.saved[s_r.central[2:0]] = 1'b1;
            end
            s_nxt.central[2:0] = chan_level(s_r.pair_prio, win);
          end
          s_nxt.st = nia_pkg::NIA_SERVE;
        end else if (cpu_in.ret && s_r.st == nia_pkg::NIA_SERVE) begin
          s_nxt.central[nia_pkg::CEN_IEN_BIT] = 1'b1;
          s_nxt.depth = s_r.depth - 4'h1;
          // lowest set stack bit restored and cleared
          if (mode_nested) begin
            s_nxt.central[2:0] = stk_any ? lowest : 3'h7;
            if (stk_any) begin
              s_nxt.saved[lowest] = 1'b0;
            end
          end
          // normal segment unless an outer nested routine resumes
          if (!mode_nested || s_r.depth <= 4'h1) begin
            s_nxt.int_seg = 1'b0;
          end
          if (s_r.depth <= 4'h1) begin
            s_nxt.st = nia_pkg::NIA_IDLE;
          end
          s_nxt.seq = 4'h1;
        end
      end
      nia_pkg::NIA_TOP: begin
        // nothing else accepted during top routine
        if (cpu_in.ret) begin
          s_nxt.top_active = 1'b0;
          s_nxt.seq = 4'h1;
          s_nxt.st = (s_r.depth == 4'h0) ? nia_pkg::NIA_IDLE : nia_pkg::NIA_SERVE;
        end
      end
      default: s_nxt.st = nia_pkg::NIA_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_r <= '0;
      s_r.central <= {5'h0, nia_pkg::RST_CPL};
      s_r.ext_vec <= nia_pkg::RST_EXT_VEC;
      s_r.srcsel <= nia_pkg::RST_SRC;
      s_r.st <= nia_pkg::NIA_IDLE;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.rdata;
  assign pslverr = 1'b0;
  assign pc_load = s_r.pc;
  assign push_seq = s_r.seq;

  always_comb begin
    cpu_out.top_req = top_en & ~s_r.top_active;
    cpu_out.irq_req = win_ok & ~s_r.top_active;
    cpu_out.chan = {1'b0, win};
    cpu_out.vec_addr = {s_r.ext_vec[7:nia_pkg::EVC_VEC_LSB], win, 1'b0};
    cpu_out.push_segment = s_r.srcsel[15];
    cpu_out.use_int_segment = s_r.int_seg;
    cpu_out.dma_block = s_r.top_active;
  end

endmodule // nia_top
